//--- src/sy_params.svh
// offsets, field positions, reset values and fixed ratios of the synthesizer
`ifndef SY_PARAMS_SVH
`define SY_PARAMS_SVH
`define SY_REG_FIRST     4'h1
`define SY_REG_LAST      4'hA
`define SY_REG_LOOP_TX   4'h1
`define SY_REG_LOOP_RX   4'h2
`define SY_REG_LO2       4'h3
`define SY_REG_CLK       4'h4
`define SY_REG_STAT      4'h5
`define SY_REG_AUDIO     4'h6
`define SY_REG_MODE      4'h7
`define SY_REG_RST       24'h000000
`define SY_N_MSB         19
`define SY_N_LSB         7
`define SY_A_MSB         6
`define SY_A_LSB         0
`define SY_GAIN_BIT      20
`define SY_LO2_N_MSB     13
`define SY_LO2_N_LSB     0
`define SY_LO2_GAIN_BIT  14
`define SY_TRIM_MSB      20
`define SY_TRIM_LSB      17
`define SY_DET_MSB       23
`define SY_DET_LSB       21
`define SY_REC_MSB       23
`define SY_REC_LSB       18
`define SY_SC_MSB        17
`define SY_SC_LSB        12
`define SY_REF_MSB       11
`define SY_REF_LSB       0
`define SY_IDLE_MSB      19
`define SY_IDLE_LSB      16
`define SY_POL_TX_BIT    22
`define SY_POL_RX_BIT    23
`define SY_POL_LO2_BIT   21
`define SY_CAP_MSB       20
`define SY_CAP_LSB       18
`define SY_MOD_MODE_BIT  13
`define SY_MONITOR_BIT   5
`define SY_MUTE_BIT      0
`define SY_ENC_DIV       5'h10
`define SY_IDLE_PRE_DIV  6'h20
`endif

//--- src/sy_pkg.sv
// types shared by the synthesizer divider files
package sy_pkg;
   typedef struct packed
   {
      logic [12:0] main_div;
      logic [6:0]  swallow;
   } sy_loop_cfg_s;

   typedef struct packed
   {
      logic up;
      logic dn;
   } sy_pump_s;
endpackage

//--- src/sy_div.sv
// programmable down counter that pulses at terminal count
`timescale 1ns/1ps
`default_nettype none
module sy_div
   import sy_pkg::*;
#(
   parameter int W = 4
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // count enable and ratio
   input  wire logic         en,
   input  wire logic [W-1:0] value,
   // terminal pulse
   output logic              tick
);
   localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
   logic [W-1:0] cnt;

   // [RULE21] reload at terminal
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= '0;
      else if (en)
         cnt <= (cnt == '0) ? value - ONE : cnt - ONE;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick <= 1'b0;
      else
         tick <= en && (cnt == '0);
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_reload;
      (en && cnt == '0) |=> (cnt == $past(value) - ONE);
   endproperty
   a_reload: assert property (p_reload) // [RULE21]
      else $error("divider did not reload programmed value");

   property p_step;
      (en && cnt != '0) |=> (cnt == $past(cnt) - ONE) && !tick;
   endproperty
   a_step: assert property (p_step) // [RULE21]
      else $error("divider step or early pulse");
endmodule // sy_div
`default_nettype wire

//--- src/sy_synth_top.sv
// synthesizer dividers, swallow counters, phase detectors and trim fields
// Notes on behaviour
// [RULE1] 12-bit reference divider gives common reference of all three loops
// [RULE2] filter clock is reference over 6-bit divider then divide by two
// [RULE3] second 6-bit divider gives 16x recovery tick, then /16 encoder tick
// [RULE4] encoder tick /32 then 4-bit counter sets idle detect delay
// [RULE5] each main loop divides prescaled input by 13-bit field of reg 1 or 2
// [RULE6] reg 1/2 bit 20 selects low or high charge pump gain
// [RULE7] reg 7 bits 22 and 23 invert main loop detector sense when set
// [RULE8] 7-bit swallow counter from reg 1/2 bits 6-0 drives modulus control
// [RULE9] reg 7 bit 13 picks voltage or current drive of modulus outputs
// [RULE10] software splits total ratio into main count and swallow remainder
// [RULE11] second oscillator loop divides its input by 14-bit field of reg 3
// [RULE12] reg 3 bit 14 gain, reg 7 bit 21 polarity of second loop
// [RULE13] reg 7 bits 20-18 select second oscillator tuning capacitor
// [RULE14] reg 3 bits 20-17 trim the internal bias reference
// [RULE15] reg 6 bit 5 selects battery or carrier monitoring
// [RULE16] reg 3 bits 23-21 select detect comparator threshold ratio
// [RULE17] reg 6 bit 0 mutes the output power amplifier
// [RULE18] ten 24-bit registers at addresses one to ten
// [RULE19] recovery divider ratio comes from reg 4 bits 23-18
// [RULE20] modulus high for swallow count of prescaler cycles, low for rest
// [RULE21] dividers reload at terminal count so changes land on boundaries
`timescale 1ns/1ps
`default_nettype none
`include "sy_params.svh"
module sy_synth_top
   import sy_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // register write port
   input  wire logic              wr_en,
   input  wire logic [3:0]        wr_addr,
   input  wire logic [23:0]       wr_data,
   // register read port
   input  wire logic [3:0]        rd_addr,
   output logic      [23:0]       rd_data,
   // prescaled oscillator pins
   input  wire logic              tx_prescaler_in,
   input  wire logic              rx_prescaler_in,
   input  wire logic              lo2_osc_in,
   // loop outputs
   output logic      [1:0]        modulus_ctrl,
   output logic                   modulus_current_mode,
   output sy_pump_s  [2:0]        pump,
   output logic      [2:0]        cp_high_gain,
   // derived clocks
   output logic                   pll_ref_tick,
   output logic                   sc_filter_clk,
   output logic                   recovery_x16_tick,
   output logic                   encoder_bit_tick,
   output logic                   idle_delay_tick,
   // analog trim and select
   output logic      [2:0]        lo2_cap_sel,
   output logic      [3:0]        bias_trim,
   output logic                   monitor_carrier,
   output logic      [2:0]        detect_ratio,
   output logic                   amp_mute
);
   localparam logic [6:0] ONE7 = 7'h01;

   logic [23:0]  regs [1:10];
   logic [2:0]   sync1;
   logic [2:0]   sync2;
   logic [2:0]   sync3;
   logic [2:0]   pre_edge;
   logic [2:0]   pfd_up;
   logic [2:0]   pfd_dn;
   logic [2:0]   next_up;
   logic [2:0]   next_dn;
   logic [2:0]   pol;
   logic [6:0]   a_cnt  [2];
   logic [6:0]   next_a [2];
   logic         sc_tick;
   logic         pre32_tick;
   wire  [2:0]   fb_tick;
   sy_loop_cfg_s loop_cfg [2];

   // [RULE18] register file
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 1; i <= 10; i++)
            regs[i] <= `SY_REG_RST;
      end
      else if (wr_en && wr_addr >= `SY_REG_FIRST && wr_addr <= `SY_REG_LAST)
         regs[wr_addr] <= wr_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= `SY_REG_RST;
      else if (rd_addr >= `SY_REG_FIRST && rd_addr <= `SY_REG_LAST)
         rd_data <= regs[rd_addr];
      else
         rd_data <= `SY_REG_RST;
   end

   // pin synchronisers and rising edge detect
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
      end
      else
      begin
         sync1 <= {lo2_osc_in, rx_prescaler_in, tx_prescaler_in};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign pre_edge = sync2 & ~sync3;

   // [RULE5] main and swallow fields
   assign loop_cfg[0] = '{main_div: regs[`SY_REG_LOOP_TX][`SY_N_MSB:`SY_N_LSB],
                          swallow:  regs[`SY_REG_LOOP_TX][`SY_A_MSB:`SY_A_LSB]};
   assign loop_cfg[1] = '{main_div: regs[`SY_REG_LOOP_RX][`SY_N_MSB:`SY_N_LSB],
                          swallow:  regs[`SY_REG_LOOP_RX][`SY_A_MSB:`SY_A_LSB]};
   // [RULE7] main loop polarity
   assign pol[0] = regs[`SY_REG_MODE][`SY_POL_TX_BIT];
   assign pol[1] = regs[`SY_REG_MODE][`SY_POL_RX_BIT];
   // [RULE12] second loop polarity
   assign pol[2] = regs[`SY_REG_MODE][`SY_POL_LO2_BIT];

   // [RULE1] loop reference divider
   sy_div #(.W(12)) u_ref_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (1'b1),
      .value (regs[`SY_REG_CLK][`SY_REF_MSB:`SY_REF_LSB]),
      .tick  (pll_ref_tick)
   );

   // [RULE2] filter clock divider
   sy_div #(.W(6)) u_sc_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (1'b1),
      .value (regs[`SY_REG_CLK][`SY_SC_MSB:`SY_SC_LSB]),
      .tick  (sc_tick)
   );

   // [RULE2] divide by two stage
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sc_filter_clk <= 1'b0;
      else if (sc_tick)
         sc_filter_clk <= ~sc_filter_clk;
   end

   // [RULE19] recovery ratio field
   sy_div #(.W(6)) u_rec_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (1'b1),
      .value (regs[`SY_REG_CLK][`SY_REC_MSB:`SY_REC_LSB]),
      .tick  (recovery_x16_tick)
   );

   // [RULE3] fixed encoder divide
   sy_div #(.W(5)) u_enc_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (recovery_x16_tick),
      .value (`SY_ENC_DIV),
      .tick  (encoder_bit_tick)
   );

   // [RULE4] fixed pre divide
   sy_div #(.W(6)) u_pre32_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (encoder_bit_tick),
      .value (`SY_IDLE_PRE_DIV),
      .tick  (pre32_tick)
   );

   // [RULE4] idle delay counter
   sy_div #(.W(4)) u_idle_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (pre32_tick),
      .value (regs[`SY_REG_STAT][`SY_IDLE_MSB:`SY_IDLE_LSB]),
      .tick  (idle_delay_tick)
   );

   // [RULE5] main counters
   for (genvar g = 0; g < 2; g++)
   begin : g_main
      sy_div #(.W(13)) u_n_div
      (
         .clk   (clk),
         .rst_n (rst_n),
         .en    (pre_edge[g]),
         .value (loop_cfg[g].main_div),
         .tick  (fb_tick[g])
      );
   end

   // [RULE11] second oscillator counter
   sy_div #(.W(14)) u_lo2_div
   (
      .clk   (clk),
      .rst_n (rst_n),
      .en    (pre_edge[2]),
      .value (regs[`SY_REG_LO2][`SY_LO2_N_MSB:`SY_LO2_N_LSB]),
      .tick  (fb_tick[2])
   );

   // [RULE20] swallow count per period
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (fb_tick[i])
            next_a[i] = loop_cfg[i].swallow;
         else if (pre_edge[i] && a_cnt[i] != 7'h00)
            next_a[i] = a_cnt[i] - ONE7;
         else
            next_a[i] = a_cnt[i];
      end
   end

   // [RULE8] modulus control outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_cnt[0]     <= 7'h00;
         a_cnt[1]     <= 7'h00;
         modulus_ctrl <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            a_cnt[i]        <= next_a[i];
            modulus_ctrl[i] <= (next_a[i] != 7'h00);
         end
      end
   end

   // [RULE1] phase detectors
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         next_up[i] = (pfd_up[i] | pll_ref_tick) & ~(pfd_dn[i] | fb_tick[i]);
         next_dn[i] = (pfd_dn[i] | fb_tick[i]) & ~(pfd_up[i] | pll_ref_tick);
      end
   end

   // [RULE7] polarity swap of pump
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pfd_up <= 3'h0;
         pfd_dn <= 3'h0;
         pump   <= '0;
      end
      else
      begin
         pfd_up <= next_up;
         pfd_dn <= next_dn;
         for (int i = 0; i < 3; i++)
         begin
            pump[i].up <= pol[i] ? next_dn[i] : next_up[i];
            pump[i].dn <= pol[i] ? next_up[i] : next_dn[i];
         end
      end
   end

   // [RULE6] main pump gains
   assign cp_high_gain[1:0] = {regs[`SY_REG_LOOP_RX][`SY_GAIN_BIT],
                               regs[`SY_REG_LOOP_TX][`SY_GAIN_BIT]};
   // [RULE12] second pump gain
   assign cp_high_gain[2] = regs[`SY_REG_LO2][`SY_LO2_GAIN_BIT];
   // [RULE9] modulus drive mode
   assign modulus_current_mode = regs[`SY_REG_MODE][`SY_MOD_MODE_BIT];
   // [RULE13] tuning capacitor code
   assign lo2_cap_sel = regs[`SY_REG_MODE][`SY_CAP_MSB:`SY_CAP_LSB];
   // [RULE14] bias trim code
   assign bias_trim = regs[`SY_REG_LO2][`SY_TRIM_MSB:`SY_TRIM_LSB];
   // [RULE15] monitor mode select
   assign monitor_carrier = regs[`SY_REG_AUDIO][`SY_MONITOR_BIT];
   // [RULE16] detect ratio code
   assign detect_ratio = regs[`SY_REG_LO2][`SY_DET_MSB:`SY_DET_LSB];
   // [RULE17] amplifier mute
   assign amp_mute = regs[`SY_REG_AUDIO][`SY_MUTE_BIT];

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_tx_load;
      fb_tick[0] && loop_cfg[0].swallow != 7'h00 && !pre_edge[0];
   endsequence
   property p_swallow_high;
      s_tx_load |=> modulus_ctrl[0] && a_cnt[0] == $past(loop_cfg[0].swallow);
   endproperty
   a_swallow_high: assert property (p_swallow_high) // [RULE20]
      else $error("modulus not raised for swallow count");

   property p_swallow_none;
      fb_tick[1] && loop_cfg[1].swallow == 7'h00 |=> !modulus_ctrl[1];
   endproperty
   a_swallow_none: assert property (p_swallow_none) // [RULE8]
      else $error("modulus raised with zero swallow");

   property p_sc_half;
      sc_tick |=> sc_filter_clk != $past(sc_filter_clk);
   endproperty
   a_sc_half: assert property (p_sc_half) // [RULE2]
      else $error("filter clock did not toggle");

   property p_enc_chain;
      encoder_bit_tick |-> $past(recovery_x16_tick);
   endproperty
   a_enc_chain: assert property (p_enc_chain) // [RULE3]
      else $error("encoder tick without recovery tick");

   property p_idle_chain;
      idle_delay_tick |-> $past(pre32_tick) && !encoder_bit_tick;
   endproperty
   a_idle_chain: assert property (p_idle_chain) // [RULE4]
      else $error("idle tick without pre divide tick");

   property p_ref_up;
      pll_ref_tick && !fb_tick[2] && !pfd_dn[2] |=> pfd_up[2];
   endproperty
   a_ref_up: assert property (p_ref_up) // [RULE1]
      else $error("reference tick did not raise detector");

   property p_pol_tx;
      pump[0].up == ($past(pol[0]) ? pfd_dn[0] : pfd_up[0]);
   endproperty
   a_pol_tx: assert property (p_pol_tx) // [RULE7]
      else $error("pump polarity wrong");

   property p_mute_wr;
      wr_en && wr_addr == `SY_REG_AUDIO |=> amp_mute == $past(wr_data[0]);
   endproperty
   a_mute_wr: assert property (p_mute_wr) // [RULE17]
      else $error("mute did not follow write");

   property p_rd_back;
      wr_en && wr_addr == rd_addr && wr_addr == `SY_REG_MODE
         ##1 rd_addr == `SY_REG_MODE |=> rd_data == $past(wr_data, 2);
   endproperty
   a_rd_back: assert property (p_rd_back) // [RULE18]
      else $error("register read back mismatch");
endmodule // sy_synth_top
`default_nettype wire

//--- verif/sy_presc_model.sv
// stand-in for the external dual-modulus prescaler and its oscillator
`timescale 1ns/1ps
`default_nettype none
module sy_presc_model
#(
   parameter int HALF = 8
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // run enable and divisor request
   input  wire logic en,
   input  wire logic modulus,
   // prescaled output pin
   output logic      pin
);
   int cnt;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 0;
         pin <= 1'b0;
      end
      else if (en)
      begin
         if (cnt >= HALF + int'(modulus))
         begin
            cnt <= 0;
            pin <= !pin;
         end
         else
            cnt <= cnt + 1;
      end
   end
endmodule // sy_presc_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the synthesizer dividers and control fields
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sy_pkg::*;
();
   logic           clk;
   logic           rst_n;
   logic           wr_en;
   logic [3:0]     wr_addr;
   logic [23:0]    wr_data;
   logic [3:0]     rd_addr;
   logic [23:0]    rd_data;
   wire  [2:0]     pins;
   logic [2:0]     pen;
   logic [1:0]     modulus_ctrl;
   logic           modulus_current_mode;
   sy_pump_s [2:0] pump;
   logic [2:0]     cp_high_gain;
   logic           pll_ref_tick;
   logic           sc_filter_clk;
   logic           recovery_x16_tick;
   logic           encoder_bit_tick;
   logic           idle_delay_tick;
   logic [2:0]     lo2_cap_sel;
   logic [3:0]     bias_trim;
   logic           monitor_carrier;
   logic [2:0]     detect_ratio;
   logic           amp_mute;
   logic [23:0]    v;
   int             failures;
   int             n_tests;
   logic [23:0]    exp_rd;
   int             hi_cnt;

   sy_synth_top sy_synth_top_inst (
      .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
      .tx_prescaler_in(pins[0]), .rx_prescaler_in(pins[1]),
      .lo2_osc_in(pins[2]), .modulus_ctrl(modulus_ctrl),
      .modulus_current_mode(modulus_current_mode), .pump(pump),
      .cp_high_gain(cp_high_gain), .pll_ref_tick(pll_ref_tick),
      .sc_filter_clk(sc_filter_clk),
      .recovery_x16_tick(recovery_x16_tick),
      .encoder_bit_tick(encoder_bit_tick),
      .idle_delay_tick(idle_delay_tick), .lo2_cap_sel(lo2_cap_sel),
      .bias_trim(bias_trim), .monitor_carrier(monitor_carrier),
      .detect_ratio(detect_ratio), .amp_mute(amp_mute));

   sy_presc_model sy_presc_model_inst [2:0] (
      .clk(clk), .rst_n(rst_n), .en(pen),
      .modulus({1'b0, modulus_ctrl}), .pin(pins));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] got,
                        input logic [23:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write, then an idle edge so strobes never merge
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      wr_en   = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(posedge clk);
      #1;
      wr_en = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [23:0] d);
      rd_addr = a;
      @(posedge clk);
      #1;
      d = rd_data;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0:       return pll_ref_tick;
         1:       return sc_filter_clk;
         2:       return recovery_x16_tick;
         3:       return encoder_bit_tick;
         default: return idle_delay_tick;
      endcase
   endfunction

   // cycles between two events; the wave counts each toggle
   task automatic gap(input int s, output logic [23:0] n);
      int   k;
      logic p;
      logic ev;
      k = 0;
      p = pick(s);
      for (int e = 0; e < 2; e++)
      begin
         n = 0;
         do
         begin
            @(posedge clk);
            #1;
            n++;
            k++;
            ev = (s == 1) ? (pick(s) !== p) : (pick(s) === 1'b1);
            p  = pick(s);
         end
         while (!ev && k < 9000);
      end
      if (k >= 9000)
      begin
         failures++;
         conclude();
      end
   endtask

   // pin edges per main period and those seen with modulus high
   task automatic pll(input int l, input int n_exp, input int a_exp);
      int   k;
      int   e;
      int   h;
      logic mq;
      logic pq;
      logic rise;
      k = 0;
      for (int w = 0; w < 2; w++)
      begin
         e  = 0;
         h  = 0;
         mq = 1'b1;
         pq = pins[l];
         do
         begin
            @(posedge clk);
            #1;
            k++;
            if (pins[l] === 1'b1 && pq === 1'b0)
            begin
               e++;
               if (modulus_ctrl[l] === 1'b1)
                  h++;
            end
            rise = (modulus_ctrl[l] === 1'b1) && (mq === 1'b0);
            mq   = modulus_ctrl[l];
            pq   = pins[l];
         end
         while (!rise && k < 30000);
      end
      if (k >= 30000)
      begin
         failures++;
         conclude();
      end
      check("main period edges", 24'(e), 24'(n_exp));
      check("high modulus edges", 24'(h), 24'(a_exp));
   endtask

   initial
   begin
      failures = 0;
      n_tests  = 0;
      rst_n    = 1'b0;
      wr_en    = 1'b0;
      wr_addr  = 4'h0;
      wr_data  = 24'h000000;
      rd_addr  = 4'h0;
      pen      = 3'h0;
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      wr(4'h4, {6'd3, 6'd5, 12'd7});
      wr(4'h5, 24'h010000);
      repeat (8) @(posedge clk);
      #1;
      check("pump", 24'(pump), 24'h00002A);
      wr(4'h7, 24'hE00000);
      repeat (8) @(posedge clk);
      #1;
      check("pump", 24'(pump), 24'h000015);
      wr(4'h3, 24'hB24000);
      check("detect_ratio", 24'(detect_ratio), 24'h000005);
      check("bias_trim", 24'(bias_trim), 24'h000009);
      wr(4'h1, 24'h100000);
      wr(4'h2, 24'h100000);
      check("cp_high_gain", 24'(cp_high_gain), 24'h000007);
      wr(4'h6, 24'h000021);
      check("mon mute", 24'({monitor_carrier, amp_mute}), 24'h3);
      wr(4'h6, 24'h000000);
      check("mon mute", 24'({monitor_carrier, amp_mute}), 24'h0);
      rd_addr = 4'h7;
      for (int c = 0; c < 8; c++)
      begin
         wr(4'h7, 24'(c) << 18);
         check("lo2_cap_sel", 24'(lo2_cap_sel), 24'(c));
         check("rd_data", rd_data, 24'(c) << 18);
      end
      check("drive mode", 24'(modulus_current_mode), 24'h0);
      wr(4'h7, 24'h002000);
      check("drive mode", 24'(modulus_current_mode), 24'h1);
      gap(0, v);
      check("ref gap", v, 24'd7);
      gap(1, v);
      check("filter half", v, 24'd5);
      gap(2, v);
      check("x16 gap", v, 24'd3);
      gap(3, v);
      check("encoder gap", v, 24'd48);
      gap(4, v);
      check("idle gap", v, 24'd1536);
      wr(4'h4, {6'd3, 6'd5, 12'd9});
      gap(0, v);
      check("ref gap", v, 24'd9);
      wr(4'h1, {4'h0, 13'(18200 / 64), 7'(18200 % 64)});
      wr(4'h2, {4'h0, 13'(8321 / 128), 7'(8321 % 128)});
      pen = 3'h7;
      pll(0, 18200 / 64, 18200 % 64);
      pll(1, 8321 / 128, 8321 % 128);
      // zero swallow keeps modulus low over whole periods
      wr(4'h2, {4'h0, 13'h0004, 7'h00});
      repeat (40) @(posedge clk);
      #1;
      hi_cnt = 0;
      repeat (1600)
      begin
         @(posedge clk);
         #1;
         if (modulus_ctrl[1] !== 1'b0)
            hi_cnt++;
      end
      check("zero swallow", 24'(hi_cnt), 24'h000000);
      for (int a = 0; a < 16; a++)
         wr(4'(a), {4'(a), 20'h5A5A5});
      for (int a = 0; a < 16; a++)
      begin
         rd(4'(a), v);
         exp_rd = (a >= 1 && a <= 10) ? {4'(a), 20'h5A5A5} : 24'h000000;
         check("rd_data", v, exp_rd);
      end
      conclude();
   end
endmodule // tb_top
`default_nettype wire
